// [inc/usr_map.svh]
// Register map constants for the USB suspend/resume and address block.
// Assumes one AXI4-Lite slave with 32-bit data; included by bare name.
`ifndef USR_MAP_SVH
`define USR_MAP_SVH
// ==========================================================================
// Offsets
`define USR_CSR0_OFF 12'h000
`define USR_CTRL_OFF 12'h004
// ==========================================================================
// Fields of the control/status word
`define USR_RESUME_BIT 10
`define USR_SUSP_BIT 9
`define USR_SUSPEND_ALLOW_BIT 8
`define USR_RSVD_BIT 7
`define USR_FUNCTION_ADDRESS_MSB 6
// Fields of the mode word
`define USR_HOSTMODE_BIT 0
// ==========================================================================
// Reset values
`define USR_CSR0_RST 32'h0000_0000
`define USR_FUNCTION_ADDRESS_RST 7'h00
// ==========================================================================
// AXI responses
`define USR_RESP_OKAY 2'h0
`define USR_RESP_SLVERR 2'h2
`endif

// [inc/usr_pkg.sv]
// Types shared by the USB suspend/resume and address block.
// Assumes the map header supplies offsets and field positions.
package usr_pkg;
  // ==========================================================================
  // Bus carriers
  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } usr_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } usr_axi_rsp_t;

  // Link-side token carrier
  typedef struct packed {
    logic valid;
    logic [6:0] addr;
  } usr_token_t;
endpackage

// [logic/usr_core.sv]
// USB suspend/resume control and device function address filter.
// Assumes an AXI4-Lite master on clk_in and link events from the same clock
// except the bus idle and remote wake levels, which are synchronised here.
// Resume timing is left to software: resume is driven while suspended for as long as the
// control bit stays set, and no counter here ends it on its own.
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "usr_map.svh"

// Behaviour
// - While suspended with resume set, resume signalling is driven; clearing resume stops it.
// - The suspend flag reads 1 while suspended and 0 in normal operation.
// - Device mode ignores writes to the suspend flag; host mode may set it, hardware clears it.
// - Suspend is entered only while suspend_allow is 1.
// - In device mode the 7-bit function address is compared against every token address.
// - Bit 7 is unimplemented, reads zero and ignores writes.
module usr_core
  import usr_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Register bus
  input wire usr_axi_req_t axi_req_in,
  output usr_axi_rsp_t axi_rsp_out,
  // Link events
  input wire logic bus_idle_in,
  input wire logic resume_seen_in,
  input wire usr_token_t token_in,
  // Link controls
  output logic resume_drive_out,
  output logic suspended_out,
  output logic token_match_out
);

  // ==========================================================================
  // State
  typedef struct packed {
    // Synchroniser stages for the two asynchronous levels
    logic [1:0] idle_sync;
    logic [1:0] wake_sync;
    // Software-visible control and status
    logic host_mode;
    logic resume;
    logic suspend_state_flag;
    logic suspend_allow;
    logic [6:0] function_address;
    // Write channel, held until both halves are in
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // Response registers
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    // Address filter result
    logic token_match;
  } usr_state_t;

  // Registered state and its next value
  usr_state_t s_q;
  usr_state_t s_d;
  // Combinational views, strobes and decodes
  logic [31:0] csr_view;
  logic wr_fire;
  logic rd_fire;
  logic idle_s;
  logic wake_s;
  logic csr0_wr;
  logic dev_entry;
  logic hw_exit;
  logic host_req;

  // ==========================================================================
  // Read view; reserved bits including bit 7 stay zero
  // Unimplemented bits keep the reset constant, so no write can ever reach them
  always_comb begin
    csr_view = `USR_CSR0_RST;
    csr_view[`USR_RESUME_BIT] = s_q.resume;
    csr_view[`USR_SUSP_BIT] = s_q.suspend_state_flag;
    csr_view[`USR_SUSPEND_ALLOW_BIT] = s_q.suspend_allow;
    csr_view[`USR_FUNCTION_ADDRESS_MSB:0] = s_q.function_address;
  end

  // Synchroniser outputs; nothing else reads the first stage
  assign idle_s = s_q.idle_sync[1];
  assign wake_s = s_q.wake_sync[1];
  // Write waits for both address and data, in either order
  assign wr_fire = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  assign rd_fire = axi_req_in.arvalid && !s_q.rvalid;

  // ==========================================================================
  // Suspend decodes, shared by the next-state logic and the checks
  // A write to the control/status word, whatever its byte lanes
  assign csr0_wr = wr_fire && (s_q.aw_addr[11:2] == 10'(`USR_CSR0_OFF >> 2));
  // Entry needs the synchronised idle level, the enable and device mode
  assign dev_entry = idle_s && s_q.suspend_allow && !s_q.host_mode;
  // Remote wake ends suspend in both modes; bus activity ends it only for a device,
  // since in host mode that activity is the block's own
  assign hw_exit = s_q.suspend_state_flag && (wake_s || (!idle_s && !s_q.host_mode));
  // A host request counts only with the upper lane written and suspend already
  // enabled; a device never sets the flag from software
  assign host_req = csr0_wr && s_q.w_strb[1] && s_q.host_mode && s_q.suspend_allow
    && s_q.w_data[`USR_SUSP_BIT];

  // ==========================================================================
  // Next-state logic
  always_comb begin
    s_d = s_q;
    // Only the second stage is read by logic
    s_d.idle_sync = {s_q.idle_sync[0], bus_idle_in};
    s_d.wake_sync = {s_q.wake_sync[0], resume_seen_in};
    // Capture address and data
    if (axi_req_in.awvalid && !s_q.aw_held) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = axi_req_in.awaddr;
    end
    if (axi_req_in.wvalid && !s_q.w_held) begin
      s_d.w_held = 1'b1;
      s_d.w_data = axi_req_in.wdata;
      s_d.w_strb = axi_req_in.wstrb;
    end
    if (s_q.bvalid && axi_req_in.bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && axi_req_in.rready) begin
      s_d.rvalid = 1'b0;
    end
    // Suspend entry from an idle bus, gated by the enable; the idle level is the
    // synchronised copy, so entry trails the pin by three edges
    if (dev_entry) begin
      s_d.suspend_state_flag = 1'b1;
    end
    // Activity or remote wake ends suspend; hardware clears the flag. The clear
    // comes after the entry, so a wake while the bus still looks idle wins
    if (hw_exit) begin
      s_d.suspend_state_flag = 1'b0;
    end
    // Register write
    // The response follows one cycle after the later of address and data
    if (wr_fire) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `USR_RESP_OKAY;
      case (s_q.aw_addr[11:2])
        10'(`USR_CSR0_OFF >> 2): begin
          if (s_q.w_strb[1]) begin
            s_d.resume = s_q.w_data[`USR_RESUME_BIT];
            s_d.suspend_allow = s_q.w_data[`USR_SUSPEND_ALLOW_BIT];
            // Host may request suspend only while allowed; a device ignores the bit.
            // This sits after the hardware clear, so a request wins a same-cycle wake
            if (host_req) begin
              s_d.suspend_state_flag = 1'b1;
            end
          end
          if (s_q.w_strb[0]) begin
            s_d.function_address = s_q.w_data[`USR_FUNCTION_ADDRESS_MSB:0];
          end
        end
        10'(`USR_CTRL_OFF >> 2): begin
          if (s_q.w_strb[0]) begin
            s_d.host_mode = s_q.w_data[`USR_HOSTMODE_BIT];
          end
        end
        default: begin
          s_d.bresp = `USR_RESP_SLVERR;
        end
      endcase
    end
    // Register read
    // Read data is registered; arready stays low while an answer waits
    if (rd_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `USR_RESP_OKAY;
      case (axi_req_in.araddr[11:2])
        10'(`USR_CSR0_OFF >> 2): s_d.rdata = csr_view;
        10'(`USR_CTRL_OFF >> 2): s_d.rdata = {31'h0, s_q.host_mode};
        default: begin
          s_d.rdata = 32'h0000_0000;
          s_d.rresp = `USR_RESP_SLVERR;
        end
      endcase
    end
    // Address filter only in device mode
    // Registered so the match pulse stands one full cycle after its token
    s_d.token_match = token_in.valid && !s_q.host_mode
      && (token_in.addr == s_q.function_address);
  end

  // ==========================================================================
  // State register
  // Synchronous reset clears every field, so the ready outputs come up high
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  // Resume drives only while suspended; software times it, as there is no counter here
  assign resume_drive_out = s_q.resume && s_q.suspend_state_flag;
  assign suspended_out = s_q.suspend_state_flag;
  assign token_match_out = s_q.token_match;
  always_comb begin
    axi_rsp_out = '0;
    axi_rsp_out.awready = !s_q.aw_held;
    axi_rsp_out.wready = !s_q.w_held;
    axi_rsp_out.bvalid = s_q.bvalid;
    axi_rsp_out.bresp = s_q.bresp;
    axi_rsp_out.arready = !s_q.rvalid;
    axi_rsp_out.rvalid = s_q.rvalid;
    axi_rsp_out.rdata = s_q.rdata;
    axi_rsp_out.rresp = s_q.rresp;
  end

  // ==========================================================================
  // Checks: resume signalling
  // Resume is driven only from the suspended state with the control bit set
  chk_resume_gate: assert property (@(posedge clk_in) disable iff (srst_in)
    resume_drive_out |-> (s_q.resume && suspended_out))
    else $error("resume driven outside suspend");
  // Clearing the control bit stops signalling in the same cycle
  chk_resume_stop: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(s_q.resume) |-> !resume_drive_out)
    else $error("resume not stopped");
  // The control bit set while suspended always reaches the bus
  chk_resume_on: assert property (@(posedge clk_in) disable iff (srst_in)
    (s_q.resume && suspended_out) |-> resume_drive_out)
    else $error("resume not driven");

  // ==========================================================================
  // Checks: suspend state
  // Every entry into suspend had the enable set the cycle before
  chk_suspend_allow: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(suspended_out) |-> $past(s_q.suspend_allow))
    else $error("suspend entered while disabled");
  // With the enable clear, suspend stays off in both modes
  chk_allow_block: assert property (@(posedge clk_in) disable iff (srst_in)
    (!s_q.suspend_allow && !suspended_out) |=> !suspended_out)
    else $error("suspend entered without enable");
  // An idle bus with the enable set puts a device into suspend
  chk_dev_entry: assert property (@(posedge clk_in) disable iff (srst_in)
    (dev_entry && !wake_s) |=> suspended_out)
    else $error("suspend entry missed");
  // A software write of the enable lands as written
  chk_allow_view: assert property (@(posedge clk_in) disable iff (srst_in)
    (csr0_wr && s_q.w_strb[1]) |=> (s_q.suspend_allow == $past(s_q.w_data[`USR_SUSPEND_ALLOW_BIT])))
    else $error("suspend enable not written");
  // In device mode software cannot set the flag
  chk_dev_susp_ro: assert property (@(posedge clk_in) disable iff (srst_in)
    (csr0_wr && !s_q.host_mode && !dev_entry) |=> !$rose(suspended_out))
    else $error("device write set suspend");
  // A host request sets the flag even against a same-cycle wake
  chk_host_set: assert property (@(posedge clk_in) disable iff (srst_in)
    host_req |=> suspended_out)
    else $error("host suspend request lost");
  // In host mode only software enters suspend
  chk_host_noentry: assert property (@(posedge clk_in) disable iff (srst_in)
    (s_q.host_mode && !suspended_out && !host_req) |=> !suspended_out)
    else $error("host suspend entered by hardware");
  // Hardware clears the flag when suspend ends
  chk_hw_exit: assert property (@(posedge clk_in) disable iff (srst_in)
    (hw_exit && !host_req) |=> !suspended_out)
    else $error("suspend not cleared");
  // A read of the control/status word returns the flag as it stood
  chk_flag_view: assert property (@(posedge clk_in) disable iff (srst_in)
    (rd_fire && axi_req_in.araddr[11:2] == 10'(`USR_CSR0_OFF >> 2))
      |=> (s_q.rdata[`USR_SUSP_BIT] == $past(suspended_out)))
    else $error("suspend flag misread");

  // ==========================================================================
  // Checks: address filter and reserved bit
  // A device token carrying the stored address is matched one cycle later
  chk_token_match: assert property (@(posedge clk_in) disable iff (srst_in)
    (token_in.valid && !s_q.host_mode && token_in.addr == s_q.function_address) |=> token_match_out)
    else $error("token match missed");
  // Any other address is not matched
  chk_match_miss: assert property (@(posedge clk_in) disable iff (srst_in)
    (token_in.valid && token_in.addr != s_q.function_address) |=> !token_match_out)
    else $error("wrong address matched");
  // No token, no match: the pulse lasts one cycle
  chk_match_pulse: assert property (@(posedge clk_in) disable iff (srst_in)
    !token_in.valid |=> !token_match_out)
    else $error("match without token");
  // The filter is off in host mode
  chk_host_nomatch: assert property (@(posedge clk_in) disable iff (srst_in)
    s_q.host_mode |=> !token_match_out)
    else $error("match in host mode");
  // The address field takes the low lane of a write
  chk_function_address_write: assert property (@(posedge clk_in) disable iff (srst_in)
    (csr0_wr && s_q.w_strb[0]) |=> (s_q.function_address == $past(s_q.w_data[`USR_FUNCTION_ADDRESS_MSB:0])))
    else $error("function address not written");
  // The unimplemented bit never shows in the view
  chk_rsvd_zero: assert property (@(posedge clk_in) disable iff (srst_in)
    !csr_view[`USR_RSVD_BIT])
    else $error("reserved bit set");
  // Nor in any read answer
  chk_rsvd_read: assert property (@(posedge clk_in) disable iff (srst_in)
    axi_rsp_out.rvalid |-> !axi_rsp_out.rdata[`USR_RSVD_BIT])
    else $error("reserved bit read as one");
endmodule

// [sim/usr_far_end.sv]
// Far-end model: the USB partner raising idle, wake and token events.
// Assumes the bench commands it just after rising edges of clk_in.
`timescale 1ns/1ps
module usr_far_end
  import usr_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Bench commands
  input wire logic idle_cmd_in,
  input wire logic wake_cmd_in,
  input wire logic tok_cmd_in,
  input wire logic [6:0] tok_addr_in,
  // Bus events
  output logic bus_idle_out,
  output logic resume_seen_out,
  output usr_token_t token_out
);
  // ======
  // Events leave one edge after the command
  always_ff @(posedge clk_in) begin
    bus_idle_out <= idle_cmd_in;
    resume_seen_out <= wake_cmd_in;
    token_out.valid <= tok_cmd_in;
    // Address toggles between tokens so a stale value never matches
    token_out.addr <= tok_cmd_in ? tok_addr_in : ~token_out.addr;
  end
endmodule

// [sim/usr_suspend_resume_addr_tb.sv]
// Bench: AXI4-Lite access, suspend, resume and address filter scenarios.
// Assumes usr_core, usr_far_end and the map header.
`timescale 1ns/1ps
`include "usr_map.svh"
module usr_suspend_resume_addr_tb;
  import usr_pkg::*;
  logic clk_in = 0;
  logic srst_in = 1;
  usr_axi_req_t req = '0;
  usr_axi_rsp_t rsp;
  logic idle = 0, wake = 0, tok = 0;
  logic [6:0] taddr = 7'h00;
  logic bus_idle, seen, drv, susp, match;
  usr_token_t token;
  int num_errors = 0, checked = 0, cyc = 0;
  logic [31:0] d;
  logic [1:0] r;
  usr_core dut_u (.clk_in(clk_in), .srst_in(srst_in), .axi_req_in(req), .axi_rsp_out(rsp),
    .bus_idle_in(bus_idle), .resume_seen_in(seen), .token_in(token), .resume_drive_out(drv),
    .suspended_out(susp), .token_match_out(match));
  usr_far_end far_u (.clk_in(clk_in), .idle_cmd_in(idle), .wake_cmd_in(wake), .tok_cmd_in(tok),
    .tok_addr_in(taddr), .bus_idle_out(bus_idle), .resume_seen_out(seen), .token_out(token));
  // ======
  // Clock and hang guard
  initial forever #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (++cyc == 5000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Ends at a falling edge so registered outputs have settled
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  // ======
  // Bus drivers; ready-low waits rely on the hang guard
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic ta, tw;
    ta = 0;
    tw = 0;
    @(posedge clk_in);
    req.awvalid <= 1; req.awaddr <= a; req.wvalid <= 1; req.wdata <= v; req.wstrb <= 4'hF;
    while (!(ta && tw)) begin
      @(negedge clk_in);
      if (rsp.awready) ta = 1;
      if (rsp.wready) tw = 1;
      @(posedge clk_in);
      if (ta) req.awvalid <= 0;
      if (tw) req.wvalid <= 0;
    end
    do @(negedge clk_in); while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    @(posedge clk_in);
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk_in);
    req.arvalid <= 1;
    req.araddr <= a;
    do @(negedge clk_in); while (rsp.arready !== 1'b1);
    @(posedge clk_in);
    req.arvalid <= 0;
    do @(negedge clk_in); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    @(posedge clk_in);
  endtask
  task automatic tk(input logic [6:0] a, input logic e);
    @(posedge clk_in);
    tok <= 1;
    taddr <= a;
    @(posedge clk_in);
    tok <= 0;
    settle(1);
    chk("token match", e, match);
    settle(0);
    chk("token match end", 0, match);
  endtask
  // ======
  // Scenarios
  task automatic test_map();
    rd(`USR_CSR0_OFF);
    chk("csr0 reset", `USR_CSR0_RST, d);
    rd(12'h008);
    chk("unmapped resp", `USR_RESP_SLVERR, r);
    chk("unmapped data", 0, d);
    $display("test map done");
  endtask
  task automatic test_addr();
    wr(`USR_CSR0_OFF, 32'h0000_00D5);
    chk("write resp", `USR_RESP_OKAY, r);
    rd(`USR_CSR0_OFF);
    chk("csr0 bit7", 32'h0000_0055, d);
    tk(7'h55, 1);
    tk(7'h54, 0);
    $display("test addr done");
  endtask
  task automatic test_dev();
    idle <= 1;
    settle(10);
    chk("suspend blocked", 0, susp);
    wr(`USR_CSR0_OFF, 32'h0000_0255);
    rd(`USR_CSR0_OFF);
    chk("device flag write", 32'h0000_0055, d);
    wr(`USR_CSR0_OFF, 32'h0000_0155);
    settle(10);
    chk("suspended", 1, susp);
    rd(`USR_CSR0_OFF);
    chk("flag read", 32'h0000_0355, d);
    wr(`USR_CSR0_OFF, 32'h0000_0555);
    settle(0);
    chk("resume drive", 1, drv);
    // Software ends resume; the wait is cut short to keep the run brief
    wr(`USR_CSR0_OFF, 32'h0000_0155);
    settle(0);
    chk("resume stop", 0, drv);
    @(posedge clk_in);
    idle <= 0;
    wake <= 1;
    settle(10);
    chk("wake leaves", 0, susp);
    @(posedge clk_in);
    wake <= 0;
    $display("test device done");
  endtask
  task automatic test_host();
    wr(`USR_CTRL_OFF, 32'h0000_0001);
    tk(7'h55, 0);
    wr(`USR_CSR0_OFF, 32'h0000_0355);
    settle(4);
    chk("host suspend set", 1, susp);
    wr(`USR_CSR0_OFF, 32'h0000_0755);
    settle(0);
    chk("host resume drive", 1, drv);
    // Host software ends downstream resume, again on a shortened wait
    wr(`USR_CSR0_OFF, 32'h0000_0155);
    settle(0);
    chk("host resume stop", 0, drv);
    chk("host flag kept", 1, susp);
    @(posedge clk_in);
    wake <= 1;
    settle(10);
    chk("host suspend clear", 0, susp);
    $display("test host done");
  endtask
  // Reset for 6 cycles, then the scenarios in order
  initial begin
    repeat (6) @(posedge clk_in);
    srst_in <= 0;
    req.bready <= 1;
    req.rready <= 1;
    test_map();
    test_addr();
    test_dev();
    test_host();
    summarize();
  end
endmodule
